// >>> dv/itd_cpu_model.sv
// Processor bus master: one-cycle accesses, read data taken two cycles on.
// Assumes the device answers reads at a fixed two-cycle latency.
`timescale 1ns/1ps
module itd_cpu_model (
  // Clock
  input wire logic clk_in,
  // Bus to the device
  output logic chip_select_high_out,
  output logic chip_select_low_out,
  output logic ram_select_n_out,
  output logic rw_out,
  output logic [6:0] addr_out,
  output logic [7:0] data_out,
  // Read return
  input wire logic [7:0] data_in,
  input wire logic data_oe_in
);
  initial begin
    chip_select_high_out = 1'b0;
    chip_select_low_out = 1'b1;
    ram_select_n_out = 1'b1;
    rw_out = 1'b1;
    addr_out = 7'h00;
    data_out = 8'h00;
  end
  // s is chip_select_low, ram_select_n, rw
  task automatic acc(input logic [2:0] s, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk_in);
    chip_select_high_out <= 1'b1;
    {chip_select_low_out, ram_select_n_out, rw_out} <= s;
    addr_out <= a;
    data_out <= d;
    @(posedge clk_in);
    // Address and data scrambled, chip_select_high_out dropped; other selects keep last value
    chip_select_high_out <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
    @(posedge clk_in);
    #1 q = data_oe_in ? data_in : 8'hxx;
  endtask
endmodule

// >>> dv/itd_io_timer_bench.sv
// Self-checking bench for the I/O, timer and decode block.
// Assumes the bus model in itd_cpu_model and port A pins resolved here.
`timescale 1ns/1ps
module itd_io_timer_bench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic chs, cls, rsn, rw, oe, irq_n, irq_oe;
  logic [6:0] a, ra;
  logic [2:0] s;
  logic [7:0] di, dq, pa, pa_oe, pb, pb_oe, d, rd;
  logic [7:0] ext_a = 8'hff;
  wire [7:0] pins = (pa_oe & pa) | (~pa_oe & ext_a);
  int n_mismatch = 0;
  int compares = 0;
  int n;
  int dv;
  localparam logic [17:0] ROWS [13] = '{{3'h2, 7'h01, 8'h5a}, {3'h3, 7'h01, 8'h5a},
    {3'h2, 7'h00, 8'h3c}, {3'h3, 7'h00, 8'hbd}, {3'h2, 7'h02, 8'hc3}, {3'h6, 7'h02, 8'h99},
    {3'h3, 7'h02, 8'hc3}, {3'h2, 7'h03, 8'h81}, {3'h3, 7'h03, 8'h81}, {3'h2, 7'h14, 8'h77},
    {3'h3, 7'h00, 8'hbd}, {3'h0, 7'h45, 8'he1}, {3'h1, 7'h45, 8'he1}};

  always #5 clk_in = ~clk_in;

  itd_cpu_model i_itd_cpu_model (.clk_in(clk_in), .chip_select_high_out(chs),
    .chip_select_low_out(cls), .ram_select_n_out(rsn), .rw_out(rw), .addr_out(a),
    .data_out(di), .data_in(dq), .data_oe_in(oe));
  itd_io_timer i_itd_io_timer (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .chip_select_high_in(chs), .chip_select_low_in(cls), .ram_select_n_in(rsn), .rw_in(rw),
    .addr_in(a), .data_in(di), .data_out(dq), .data_oe_out(oe), .port_a_pin_in(pins),
    .port_a_out(pa), .port_a_oe_out(pa_oe), .port_b_pin_in(8'h00), .port_b_out(pb),
    .port_b_oe_out(pb_oe), .irq_n_out(irq_n), .irq_oe_out(irq_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
  endtask

  task automatic wait_irq;
    n = 0;
    while (irq_n !== 1'b0) begin
      @(posedge clk_in);
      n++;
      if (n > 4000) begin
        n_mismatch++;
        test_done();
      end
    end
  endtask

  task automatic acc(input logic [2:0] st, input logic [6:0] ad, input logic [7:0] wd);
    i_itd_cpu_model.acc(st, ad, wd, rd);
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 13; i++) begin
      {s, ra, d} = ROWS[i];
      acc(s, ra, d);
      if (s[0]) chk(rd, d);
    end
    acc(3'h2, 7'h01, 8'h00);
    $display("test table done");
    do_reset();
    chk(pa | pa_oe | pb | pb_oe, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h00);
    $display("test reset done");
    acc(3'h2, 7'h16, 8'h05);
    repeat (100) @(posedge clk_in);
    acc(3'h3, 7'h04, 8'h00);
    chk(rd, 8'h03);
    for (int p = 0; p < 4; p++) begin
      dv = (p == 3) ? 1024 : 1 << (3 * p);
      acc(3'h2, {5'h07, p[1:0]}, 8'h02);
      wait_irq();
      chk({7'h00, n >= 2 * dv && n <= 2 * dv + 4}, 8'h01);
      repeat (16) @(posedge clk_in);
      acc(3'h3, 7'h04, 8'h00);
      chk({7'h00, rd >= 8'he6 && rd <= 8'hf0}, 8'h01);
      chk({7'h00, irq_n}, 8'h01);
      acc(3'h3, 7'h05, 8'h00);
      chk(rd, 8'h00);
    end
    // Count of one at 1T: the next read lands on the edge the flag sets
    acc(3'h2, 7'h14, 8'h01);
    acc(3'h3, 7'h04, 8'h00);
    chk(rd, 8'hff);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h80);
    acc(3'h2, 7'h17, 8'hff);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h00);
    $display("test timer done");
    @(posedge clk_in);
    ext_a <= 8'h7f;
    repeat (4) @(posedge clk_in);
    chk({7'h00, irq_n}, 8'h01);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h40);
    acc(3'h2, 7'h07, 8'h00);
    @(posedge clk_in);
    ext_a <= 8'hff;
    wait_irq();
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h40);
    chk({7'h00, irq_n}, 8'h01);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h00);
    acc(3'h2, 7'h04, 8'h00);
    @(posedge clk_in);
    ext_a <= 8'h7f;
    repeat (4) @(posedge clk_in);
    chk({7'h00, irq_n}, 8'h01);
    acc(3'h3, 7'h05, 8'h00);
    chk(rd, 8'h40);
    $display("test edge done");
    test_done();
  end
endmodule

// >>> dv/itd_io_timer_props.sv
// Bus, port and interrupt checks on the top ports of the block.
// Assumes one-cycle accesses and read data two cycles after the access edge.
`timescale 1ns/1ps
module itd_io_timer_props #(
  parameter int RAM_DEPTH = 128
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Processor bus
  input wire logic chip_select_high_in,
  input wire logic chip_select_low_in,
  input wire logic ram_select_n_in,
  input wire logic rw_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  // Ports
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_out,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_out,
  // Interrupt
  input wire logic irq_n_out,
  input wire logic irq_oe_out
);
  wire sel = chip_select_high_in && !chip_select_low_in;
  wire io = sel && ram_select_n_in;
  wire rd = sel && rw_in;
  wire io_wr = io && !rw_in && !addr_in[2];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_irq_open_drain: assert property (irq_oe_out == !irq_n_out)
    else $error("irq enable disagrees with level");
  a_reset_clear: assert property ($rose(rst_b_in) |-> !data_oe_out && irq_n_out
    && (port_a_out | port_a_oe_out | port_b_out | port_b_oe_out) == 8'h00)
    else $error("outputs not cleared by reset");
  a_read_drives: assert property (rd |-> ##2 data_oe_out)
    else $error("selected read not answered");
  a_no_stray_drive: assert property (data_oe_out |-> $past(rd, 2))
    else $error("bus driven without a read");
  a_flag_low_zero: assert property (io && rw_in && addr_in[2] && addr_in[0]
    |-> ##2 data_out[5:0] == 6'h00) else $error("flag read low bits not zero");
  a_port_b_regread: assert property (io && rw_in && addr_in[2:0] == 3'h2
    |-> ##2 data_out == $past(port_b_out, 2)) else $error("port b read not register");
  a_port_a_write: assert property (io_wr && addr_in[1:0] == 2'h0
    |=> port_a_out == $past(data_in)) else $error("port a output write lost");
  a_dir_a_write: assert property (io_wr && addr_in[1:0] == 2'h1
    |=> port_a_oe_out == $past(data_in)) else $error("port a direction write lost");
  a_unsel_hold: assert property (!sel |=> $stable(port_b_out) && $stable(port_b_oe_out))
    else $error("unselected cycle changed port b");
  a_timer_side_keep: assert property (io && !rw_in && addr_in[2]
    |=> $stable(port_a_out) && $stable(port_a_oe_out)) else $error("timer write hit port a");
  cover property (io && !rw_in && addr_in[2] && addr_in[4]);
  cover property ($fell(irq_n_out));
  cover property (io && rw_in && addr_in[2] && addr_in[0]);
endmodule

bind itd_io_timer itd_io_timer_props #(.RAM_DEPTH(RAM_DEPTH)) i_itd_io_timer_props (
  .clk_in, .rst_b_in, .chip_select_high_in, .chip_select_low_in, .ram_select_n_in,
  .rw_in, .addr_in, .data_in, .data_out, .data_oe_out, .port_a_pin_in, .port_a_out,
  .port_a_oe_out, .port_b_pin_in, .port_b_out, .port_b_oe_out, .irq_n_out, .irq_oe_out);

// >>> logic/itd_interval_timer.sv
// Prescaled 8-bit down-counter with free run after timeout.
// Assumes load comes from the timer write decode of the parent and free-run control from its timer flag.
`timescale 1ns/1ps

module itd_interval_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic load_in,
  input wire logic [7:0] load_value_in,
  input wire logic [1:0] prescale_in,
  input wire logic free_run_in,
  // Status
  output logic [7:0] count_out,
  output logic expire_out
);

  logic [1:0] prescale;
  logic [9:0] psc_cnt;
  logic [1:0] next_prescale;
  logic [9:0] next_psc_cnt;
  logic [7:0] next_count;
  logic next_expire;
  logic tick;

  function automatic logic [9:0] last_of(input logic [1:0] sel);
    unique case (sel)
      itd_pkg::PRESCALE_1: last_of = itd_pkg::PRESCALE_1_LAST;
      itd_pkg::PRESCALE_8: last_of = itd_pkg::PRESCALE_8_LAST;
      itd_pkg::PRESCALE_64: last_of = itd_pkg::PRESCALE_64_LAST;
      itd_pkg::PRESCALE_1024: last_of = itd_pkg::PRESCALE_1024_LAST;
    endcase
  endfunction

  always_comb begin
    // After timeout every clock is a tick, see [RULE5]
    tick = free_run_in || (psc_cnt == last_of(prescale)); // see [RULE1]
    next_prescale = prescale;
    next_psc_cnt = tick ? 10'h000 : psc_cnt + 10'h001;
    next_count = tick ? count_out - 8'h01 : count_out; // see [RULE2]
    // Passing through zero reads as all ones, see [RULE4]
    next_expire = !load_in && !free_run_in && tick && (count_out == 8'h00);
    if (load_in) begin
      next_prescale = prescale_in; // see [RULE1]
      // First interval ends on the next clock, so a read gives whole intervals left
      next_psc_cnt = last_of(prescale_in); // see [RULE3]
      next_count = load_value_in; // see [RULE2]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prescale <= itd_pkg::PRESCALE_RESET;
      psc_cnt <= 10'h000;
      count_out <= itd_pkg::COUNT_RESET;
      expire_out <= 1'b0;
    end else begin
      prescale <= next_prescale;
      psc_cnt <= next_psc_cnt;
      count_out <= next_count;
      expire_out <= next_expire;
    end
  end

endmodule

// >>> logic/itd_io_timer.sv
// RAM, I/O ports, interval timer and interrupt flags behind one address decode.
// Assumes bus inputs are synchronous to clk_in; each selected access lasts one cycle.
`timescale 1ns/1ps

// How it works
// [RULE1] Timer write A1:A0 picks 1/8/64/1024 prescale
// [RULE2] Written byte loads count, decremented per interval
// [RULE3] Timer read before flag gives remaining intervals
// [RULE4] One interval past zero: flag set, all ones
// [RULE5] After flag, count decrements every clock
// [RULE6] Timer access latches A3 as timer enable
// [RULE7] Any timer access clears timer flag
// [RULE8] Read coinciding with flag set keeps flag
// [RULE9] Flag read: timer bit7, edge bit6, rest zero
// [RULE10] Flag read clears edge flag only
// [RULE11] Chip selects and RAM select pick section
// [RULE12] A2 high timer, low I/O registers
// [RULE13] A1:A0 pick one of four I/O registers
// [RULE14] A4 splits timer write from edge control
// [RULE15] A0 splits timer read from flag read
// [RULE16] Selected edge on bit 7 always sets flag
// [RULE17] Enabled edge flag pulls interrupt low
// [RULE18] Reset disables edge interrupt, selects falling
// [RULE19] Host reads flags after reset before enabling
// [RULE20] Host holds A3 low reading after timeout
// [RULE21] Reset clears ports, bus off, interrupts off
// [RULE22] Interrupt output active low, open drain
// [RULE23] Direction one drives pin from output register
// [RULE24] Port A reads pins, port B register
// [RULE25] Interrupt from enabled timer or edge flag
// [RULE26] Data bus driven only for selected reads
module itd_io_timer #(
  parameter int RAM_DEPTH = itd_pkg::RAM_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Processor bus selects
  input wire logic chip_select_high_in,
  input wire logic chip_select_low_in,
  input wire logic ram_select_n_in,
  input wire logic rw_in,
  input wire logic [itd_pkg::ADDR_W-1:0] addr_in,
  // Processor data bus
  input wire logic [itd_pkg::DATA_W-1:0] data_in,
  output logic [itd_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  // Port A
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_out,
  // Port B
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_out,
  // Interrupt request, open drain
  output logic irq_n_out,
  output logic irq_oe_out
);

  initial begin
    if (RAM_DEPTH < 1 || RAM_DEPTH > (1 << itd_pkg::ADDR_W)) begin
      $error("itd_io_timer: RAM depth does not fit seven address lines");
    end
    if (itd_pkg::A4_POS >= itd_pkg::ADDR_W) begin
      $error("itd_io_timer: decode needs address bit A4");
    end
  end

  // Decode of the I/O register picked by A1:A0
  function automatic logic [1:0] io_pick(input logic [itd_pkg::ADDR_W-1:0] a);
    io_pick = {a[itd_pkg::A1_POS], a[itd_pkg::A0_POS]};
  endfunction

  // Section decode
  logic chip_sel;
  logic ram_sel;
  logic io_sec;
  logic timer_sec;
  logic reg_sec;
  logic ram_wr;
  logic ram_rd;
  logic reg_wr;
  logic reg_rd;
  logic timer_wr;
  logic edge_wr;
  logic timer_rd;
  logic flag_rd;
  logic timer_access;

  always_comb begin
    chip_sel = chip_select_high_in && !chip_select_low_in; // see [RULE11]
    ram_sel = chip_sel && !ram_select_n_in; // see [RULE11]
    io_sec = chip_sel && ram_select_n_in; // see [RULE11]
    timer_sec = io_sec && addr_in[itd_pkg::A2_POS]; // see [RULE12]
    reg_sec = io_sec && !addr_in[itd_pkg::A2_POS]; // see [RULE12]
    ram_wr = ram_sel && !rw_in;
    ram_rd = ram_sel && rw_in;
    reg_wr = reg_sec && !rw_in;
    reg_rd = reg_sec && rw_in;
    timer_wr = timer_sec && !rw_in && addr_in[itd_pkg::A4_POS]; // see [RULE14]
    edge_wr = timer_sec && !rw_in && !addr_in[itd_pkg::A4_POS]; // see [RULE14]
    timer_rd = timer_sec && rw_in && !addr_in[itd_pkg::A0_POS]; // see [RULE15]
    flag_rd = timer_sec && rw_in && addr_in[itd_pkg::A0_POS]; // see [RULE15]
    timer_access = timer_wr || timer_rd;
  end

  // Port registers
  logic [7:0] port_a_output;
  logic [7:0] port_a_direction;
  logic [7:0] port_b_output;
  logic [7:0] port_b_direction;
  logic [7:0] next_port_a_output;
  logic [7:0] next_port_a_direction;
  logic [7:0] next_port_b_output;
  logic [7:0] next_port_b_direction;

  always_comb begin
    next_port_a_output = port_a_output;
    next_port_a_direction = port_a_direction;
    next_port_b_output = port_b_output;
    next_port_b_direction = port_b_direction;
    if (reg_wr) begin
      unique case (io_pick(addr_in)) // see [RULE13]
        itd_pkg::IO_PORT_A_OUT: next_port_a_output = data_in;
        itd_pkg::IO_PORT_A_DIR: next_port_a_direction = data_in;
        itd_pkg::IO_PORT_B_OUT: next_port_b_output = data_in;
        itd_pkg::IO_PORT_B_DIR: next_port_b_direction = data_in;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      port_a_output <= itd_pkg::PORT_RESET; // see [RULE21]
      port_a_direction <= itd_pkg::PORT_RESET;
      port_b_output <= itd_pkg::PORT_RESET;
      port_b_direction <= itd_pkg::PORT_RESET;
    end else begin
      port_a_output <= next_port_a_output;
      port_a_direction <= next_port_a_direction;
      port_b_output <= next_port_b_output;
      port_b_direction <= next_port_b_direction;
    end
  end

  // Pins follow the registers directly, see [RULE23]
  assign port_a_out = port_a_output;
  assign port_a_oe_out = port_a_direction;
  assign port_b_out = port_b_output;
  assign port_b_oe_out = port_b_direction;

  // Edge detect on port A bit 7
  logic port_a_bit7_edge_pin;
  logic edge_seen;
  logic edge_irq_en;
  logic edge_rising;
  logic next_edge_irq_en;
  logic next_edge_rising;
  logic edge_prev;
  logic next_edge_prev;

  assign port_a_bit7_edge_pin = port_a_pin_in[7];

  always_comb begin
    next_edge_irq_en = edge_irq_en;
    next_edge_rising = edge_rising;
    next_edge_prev = port_a_bit7_edge_pin;
    if (edge_wr) begin
      // Data lines are ignored here, see [RULE14]
      next_edge_irq_en = addr_in[itd_pkg::A1_POS];
      next_edge_rising = addr_in[itd_pkg::A0_POS];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      edge_irq_en <= 1'b0; // see [RULE18]
      edge_rising <= itd_pkg::EDGE_RISING_RESET; // see [RULE18]
      edge_prev <= 1'b1;
    end else begin
      edge_irq_en <= next_edge_irq_en;
      edge_rising <= next_edge_rising;
      edge_prev <= next_edge_prev;
    end
  end

  // Pin level is sampled whatever its direction, see [RULE16]
  always_comb begin
    edge_seen = edge_rising ? (port_a_bit7_edge_pin && !edge_prev)
                            : (!port_a_bit7_edge_pin && edge_prev);
  end

  // Interval timer
  logic [7:0] timer_count;
  logic timer_expire;
  logic timer_flag;
  logic timer_irq_en;
  logic next_timer_flag;
  logic next_timer_irq_en;

  itd_interval_timer u_timer (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .load_in(timer_wr),
    .load_value_in(data_in),
    .prescale_in(io_pick(addr_in)),
    .free_run_in(timer_flag),
    .count_out(timer_count),
    .expire_out(timer_expire)
  );

  always_comb begin
    next_timer_irq_en = timer_irq_en;
    if (timer_access) begin
      next_timer_irq_en = addr_in[itd_pkg::A3_POS]; // see [RULE6]
    end
    next_timer_flag = timer_flag;
    if (timer_access) begin
      next_timer_flag = 1'b0; // see [RULE7]
    end
    // Expiry wins over a coinciding read, see [RULE8]
    if (timer_expire && !timer_wr) begin
      next_timer_flag = 1'b1; // see [RULE4]
    end
  end

  // Edge flag: set wins over the clear by a flag read
  logic edge_flag;
  logic next_edge_flag;

  always_comb begin
    next_edge_flag = edge_flag;
    if (flag_rd) begin
      next_edge_flag = 1'b0; // see [RULE10]
    end
    if (edge_seen) begin
      next_edge_flag = 1'b1; // see [RULE16]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      timer_flag <= 1'b0;
      timer_irq_en <= 1'b0; // see [RULE21]
      edge_flag <= 1'b0;
    end else begin
      timer_flag <= next_timer_flag;
      timer_irq_en <= next_timer_irq_en;
      edge_flag <= next_edge_flag;
    end
  end

  // RAM array
  logic [7:0] ram_rdata;

  itd_ram #(
    .DEPTH(RAM_DEPTH),
    .WIDTH(itd_pkg::DATA_W),
    .AW(itd_pkg::ADDR_W)
  ) u_ram (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(ram_wr),
    .addr_in(addr_in),
    .wdata_in(data_in),
    .rdata_out(ram_rdata)
  );

  // Read path: value chosen at the access edge, driven on the next edge
  logic [7:0] reg_rdata;
  logic [7:0] rd_hold;
  logic rd_from_ram;
  logic rd_pend;
  logic [7:0] next_rd_hold;
  logic next_rd_from_ram;
  logic next_rd_pend;
  logic [7:0] next_data_out;
  logic next_data_oe;

  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (io_pick(addr_in)) // see [RULE13]
        itd_pkg::IO_PORT_A_OUT: reg_rdata = port_a_pin_in; // see [RULE24]
        itd_pkg::IO_PORT_A_DIR: reg_rdata = port_a_direction;
        itd_pkg::IO_PORT_B_OUT: reg_rdata = port_b_output; // see [RULE24]
        itd_pkg::IO_PORT_B_DIR: reg_rdata = port_b_direction;
      endcase
    end else if (timer_rd) begin
      reg_rdata = timer_count; // see [RULE3]
    end else if (flag_rd) begin
      reg_rdata[itd_pkg::FLAG_TIMER_POS] = timer_flag; // see [RULE9]
      reg_rdata[itd_pkg::FLAG_EDGE_POS] = edge_flag;
    end
  end

  always_comb begin
    next_rd_hold = reg_rdata;
    next_rd_from_ram = ram_rd;
    next_rd_pend = ram_rd || reg_rd || timer_rd || flag_rd; // see [RULE26]
    next_data_out = rd_from_ram ? ram_rdata : rd_hold;
    next_data_oe = rd_pend;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_hold <= 8'h00;
      rd_from_ram <= 1'b0;
      rd_pend <= 1'b0;
      data_out <= 8'h00;
      data_oe_out <= 1'b0; // see [RULE21]
    end else begin
      rd_hold <= next_rd_hold;
      rd_from_ram <= next_rd_from_ram;
      rd_pend <= next_rd_pend;
      data_out <= next_data_out;
      data_oe_out <= next_data_oe; // see [RULE26]
    end
  end

  // Interrupt output
  logic irq_active;
  logic next_irq_n;
  logic next_irq_oe;

  always_comb begin
    irq_active = (timer_flag && timer_irq_en) // see [RULE25]
              || (edge_flag && edge_irq_en); // see [RULE17]
    next_irq_n = !irq_active; // see [RULE22]
    next_irq_oe = irq_active;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      irq_n_out <= 1'b1;
      irq_oe_out <= 1'b0;
    end else begin
      irq_n_out <= next_irq_n;
      irq_oe_out <= next_irq_oe;
    end
  end

endmodule

// >>> logic/itd_pkg.sv
// Constants shared by the I/O, timer and address decode block.
// Assumes an 8-bit data bus and seven address lines from the processor.
package itd_pkg;

  // Bus widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int RAM_DEPTH = 128;

  // Address bit positions used by the decode
  localparam int A0_POS = 0;
  localparam int A1_POS = 1;
  localparam int A2_POS = 2;
  localparam int A3_POS = 3;
  localparam int A4_POS = 4;

  // I/O register selection by A1:A0
  localparam logic [1:0] IO_PORT_A_OUT = 2'h0;
  localparam logic [1:0] IO_PORT_A_DIR = 2'h1;
  localparam logic [1:0] IO_PORT_B_OUT = 2'h2;
  localparam logic [1:0] IO_PORT_B_DIR = 2'h3;

  // Prescale selection by A1:A0 on a timer write
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_8 = 2'h1;
  localparam logic [1:0] PRESCALE_64 = 2'h2;
  localparam logic [1:0] PRESCALE_1024 = 2'h3;

  // Terminal values of the prescale counter, one less than each divisor
  localparam logic [9:0] PRESCALE_1_LAST = 10'h000;
  localparam logic [9:0] PRESCALE_8_LAST = 10'h007;
  localparam logic [9:0] PRESCALE_64_LAST = 10'h03f;
  localparam logic [9:0] PRESCALE_1024_LAST = 10'h3ff;

  // Interrupt flag register layout
  localparam int FLAG_TIMER_POS = 7;
  localparam int FLAG_EDGE_POS = 6;

  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [1:0] PRESCALE_RESET = PRESCALE_1024;
  localparam logic EDGE_RISING_RESET = 1'b0;

endpackage

// >>> logic/itd_ram.sv
// Static RAM array behind the RAM select.
// Assumes write enable and address come from the decode in the same cycle.
`timescale 1ns/1ps

module itd_ram #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8,
  parameter int AW = 7
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Access
  input wire logic wr_en_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] rdata_out
);

  initial begin
    if (DEPTH > (1 << AW) || DEPTH < 1) begin
      $error("itd_ram: depth does not fit the address width");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[addr_in];
    end
  end

endmodule
